// ### low_power_mode_wake_control.sv
/*
 * Low-power mode and wake controller: sequences active, sleep, deep-sleep
 * and deep power-down, gates clocks, power and flash standby, and decides
 * which enabled sources may end deep-sleep; a hardware wake request also
 * ends sleep, any rtc alarm deep power-down. Registers over classic Wishbone.
 * Assumes synchronous wake inputs and an interrupt controller that reports
 * its pending-and-enabled set on irqEnabledPending.
 */
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module low_power_mode_wake_control
    import lp_pkg::*;
#(
    parameter int PIN_W = lp_pkg::PIN_IRQ_W,
    parameter int PER_W = lp_pkg::PERIPH_W
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire lp_pkg::wb_req_s wbReq,
    output lp_pkg::wb_rsp_s wbRsp,
    input wire lp_pkg::wake_src_s wakeSrc,
    input wire logic [31:0] irqEnabledPending,
    input wire logic [31:0] irqSrcMap,
    input wire logic rtcCounterLoaded,
    input wire logic [PER_W-1:0] periphKeepClock,
    output logic coreClkEn,
    output logic mainClkEn,
    output logic [PER_W-1:0] periphClkEn,
    output logic flashStandby,
    output logic [4:0] analogPowerOn,
    output logic dmaEn,
    output logic retainState,
    output logic pinHold,
    output logic pinFloat,
    output logic coreResume,
    output logic chipResetReq,
    output logic rtcWakeIrq,
    output logic [1:0] powerState
);
    import lp_pkg::*;

    lp_state_e stateReg;
    lp_state_e stateNext;
    logic [31:0] modeCtrlReg;
    logic [31:0] wakeEn0Reg;
    logic [31:0] wakeEn1Reg;
    logic [31:0] pdRunCfgReg;
    logic [31:0] busClkEn0Reg;
    logic [31:0] brownoutCtrlReg;
    logic [31:0] wdtModeReg;
    logic [31:0] rtcOscCtrlReg;
    logic [31:0] periphKeepReg;
    logic [31:0] wakeCauseReg;
    logic [$clog2(POR_SEQ_CYCLES+1)-1:0] porCntReg;
    logic ackReg;
    logic [31:0] rdataReg;
    logic rtcFlagPrevReg;
    logic [31:0] rdataNext;

    // byte-enable merge for a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic busHit;
    logic wrStb;
    assign busHit = wbReq.cyc && wbReq.stb && !ackReg;
    assign wrStb = busHit && wbReq.we;

    // wake qualification
    logic pinWake;
    logic brownoutWake;
    logic brownoutRstWake;
    logic wdtWake;
    logic wdtRstWake;
    logic rtcWake;
    logic serialWake;
    logic dmaWake;
    logic deepSleepWake;
    logic sleepWake;
    logic wdtArmed;
    logic [PIN_W-1:0] pinEnabled;

    assign pinEnabled = irqSrcMap[PIN_W-1:0] & {wakeEn1Reg[PIN_W-1:0]};
    assign pinWake = |(wakeSrc.pinIrq & pinEnabled)
        || (wakeSrc.groupIrq && wakeEn1Reg[PIN_W]);
    assign brownoutWake = wakeSrc.brownoutIrq && irqSrcMap[PIN_W]
        && wakeEn0Reg[WE_BROWNOUT] && brownoutCtrlReg[BO_INT_EN]
        && pdRunCfgReg[PD_BROWNOUT];
    assign brownoutRstWake = wakeSrc.brownoutRst && brownoutCtrlReg[BO_RST_EN];
    assign wdtArmed = pdRunCfgReg[PD_WDT_OSC] && wdtModeReg[WDM_ENABLE] && wakeSrc.watchdogFed;
    assign wdtWake = wakeSrc.watchdogIrq && wdtArmed && irqSrcMap[PIN_W+1]
        && wakeEn0Reg[WE_WATCHDOG] && wdtModeReg[WDM_INT];
    assign wdtRstWake = wakeSrc.watchdogRst && wdtArmed && wdtModeReg[WDM_RESET];
    assign rtcWake = rtcWakeIrq && rtcOscCtrlReg[RTC_OSC_1HZ] && busClkEn0Reg[BUS_CLK_RTC]
        && rtcCounterLoaded && wakeEn0Reg[WE_RTC_ALARM];
    assign serialWake = (wakeSrc.usartIrq && wakeEn0Reg[WE_USART]
            && (periphKeepReg[PK_USART_SYNC] || periphKeepReg[PK_USART_32K]))
        || (wakeSrc.spiIrq && wakeEn0Reg[WE_SPI] && periphKeepReg[PK_SPI_SLAVE])
        || (wakeSrc.i2cIrq && wakeEn0Reg[WE_I2C] && periphKeepReg[PK_I2C_SLAVE]);
    assign dmaWake = wakeSrc.dmaIrq && wakeEn0Reg[WE_DMA] && periphKeepReg[PK_DMA_DS];
    assign deepSleepWake = pinWake || brownoutWake || wdtWake || rtcWake || serialWake
        || dmaWake;
    assign sleepWake = (|irqEnabledPending) || wakeSrc.hardwareWakeRequest;

    logic enterReq;
    lp_mode_e reqMode;
    assign enterReq = wrStb && wbReq.adr == ADDR_MODE_CTRL && wbReq.sel[0]
        && wbReq.dat[ENTER_BIT];
    assign reqMode = lp_mode_e'(wbReq.dat[MODE_LSB +: 2]);

    // state machine
    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            ST_ACTIVE: begin
                if (enterReq) begin
                    case (reqMode)
                        MODE_SLEEP: stateNext = ST_SLEEP;
                        MODE_DEEP_SLEEP: stateNext = ST_DEEP_SLEEP;
                        MODE_DEEP_PD: stateNext = ST_DEEP_PD;
                        default: stateNext = ST_ACTIVE;
                    endcase
                end
            end
            ST_SLEEP: begin
                if (sleepWake) begin
                    stateNext = ST_ACTIVE;
                end
            end
            ST_DEEP_SLEEP: begin
                if (brownoutRstWake || wdtRstWake) begin
                    stateNext = ST_POR_SEQ;
                end else if (deepSleepWake) begin
                    stateNext = ST_ACTIVE;
                end
            end
            ST_DEEP_PD: begin
                if (rtcWakeIrq) begin
                    stateNext = ST_POR_SEQ;
                end
            end
            ST_POR_SEQ: begin
                if (porCntReg == ($bits(porCntReg))'(POR_SEQ_CYCLES - 1)) begin
                    stateNext = ST_ACTIVE;
                end
            end
            default: stateNext = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= ST_ACTIVE;
        end else begin
            stateReg <= stateNext;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            porCntReg <= '0;
        end else if (stateReg == ST_POR_SEQ) begin
            porCntReg <= porCntReg + 1'b1;
        end else begin
            porCntReg <= '0;
        end
    end

    // rtc alarm request: rising edge of the flag sets it, held until the flag falls
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rtcFlagPrevReg <= 1'b0;
            rtcWakeIrq <= 1'b0;
        end else begin
            rtcFlagPrevReg <= wakeSrc.oneHertzAlarmFlag;
            if (wakeSrc.oneHertzAlarmFlag && !rtcFlagPrevReg) begin
                rtcWakeIrq <= 1'b1;
            end else if (!wakeSrc.oneHertzAlarmFlag) begin
                rtcWakeIrq <= 1'b0;
            end
        end
    end

    // config registers; the reset sequence after deep power-down or a deep-sleep reset wake wipes them, the rtc domain bits survive
    logic pdWipe;
    assign pdWipe = stateReg == ST_POR_SEQ && porCntReg == '0;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            modeCtrlReg <= RST_ZERO;
            wakeEn0Reg <= RST_ZERO;
            wakeEn1Reg <= RST_ZERO;
            pdRunCfgReg <= RST_PD_RUN_CFG;
            busClkEn0Reg <= RST_ZERO;
            brownoutCtrlReg <= RST_ZERO;
            wdtModeReg <= RST_ZERO;
            periphKeepReg <= RST_ZERO;
        end else if (pdWipe) begin
            modeCtrlReg <= RST_ZERO;
            wakeEn0Reg <= RST_ZERO;
            wakeEn1Reg <= RST_ZERO;
            pdRunCfgReg <= RST_PD_RUN_CFG;
            busClkEn0Reg <= RST_ZERO;
            brownoutCtrlReg <= RST_ZERO;
            wdtModeReg <= RST_ZERO;
            periphKeepReg <= RST_ZERO;
        end else if (wrStb) begin
            if (wbReq.adr == ADDR_MODE_CTRL) begin
                modeCtrlReg <= merge(modeCtrlReg, wbReq.dat & ~(32'h1 << ENTER_BIT), wbReq.sel);
            end else if (wbReq.adr == ADDR_WAKE_EN0) begin
                wakeEn0Reg <= merge(wakeEn0Reg, wbReq.dat, wbReq.sel);
            end else if (wbReq.adr == ADDR_WAKE_EN1) begin
                wakeEn1Reg <= merge(wakeEn1Reg, wbReq.dat, wbReq.sel);
            end else if (wbReq.adr == ADDR_PD_RUN_CFG) begin
                pdRunCfgReg <= merge(pdRunCfgReg, wbReq.dat, wbReq.sel);
            end else if (wbReq.adr == ADDR_BUS_CLK_EN0) begin
                busClkEn0Reg <= merge(busClkEn0Reg, wbReq.dat, wbReq.sel);
            end else if (wbReq.adr == ADDR_BROWNOUT_CTRL) begin
                brownoutCtrlReg <= merge(brownoutCtrlReg, wbReq.dat, wbReq.sel);
            end else if (wbReq.adr == ADDR_WDT_MODE) begin
                // watchdog mode bits lock once set until reset
                wdtModeReg <= wdtModeReg | merge(wdtModeReg, wbReq.dat, wbReq.sel);
            end else if (wbReq.adr == ADDR_PERIPH_KEEP) begin
                periphKeepReg <= merge(periphKeepReg, wbReq.dat, wbReq.sel);
            end
        end
    end

    // rtc oscillator control lives in the always-on domain: no wipe on deep power-down
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rtcOscCtrlReg <= RST_ZERO;
        end else if (wrStb && wbReq.adr == ADDR_RTC_OSC_CTRL) begin
            rtcOscCtrlReg <= merge(rtcOscCtrlReg, wbReq.dat, wbReq.sel);
        end
    end

    // wake cause: sticky, set wins over a software clear (write one to clear)
    logic [31:0] causeSet;
    assign causeSet = {24'h0, rtcWakeIrq && stateReg == ST_DEEP_PD, wdtRstWake, brownoutRstWake,
        dmaWake || serialWake, rtcWake, wdtWake, brownoutWake, pinWake}
        & {32{stateReg == ST_DEEP_SLEEP || stateReg == ST_DEEP_PD}};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeCauseReg <= RST_ZERO;
        end else begin
            if (wrStb && wbReq.adr == ADDR_WAKE_CAUSE) begin
                wakeCauseReg <= (wakeCauseReg & ~merge(32'h0, wbReq.dat, wbReq.sel)) | causeSet;
            end else begin
                wakeCauseReg <= wakeCauseReg | causeSet;
            end
        end
    end

    // wishbone slave: one wait state, ack one cycle after strobe
    always_comb begin
        rdataNext = RST_ZERO;
        if (wbReq.adr == ADDR_MODE_CTRL) begin
            rdataNext = modeCtrlReg;
        end else if (wbReq.adr == ADDR_WAKE_EN0) begin
            rdataNext = wakeEn0Reg;
        end else if (wbReq.adr == ADDR_WAKE_EN1) begin
            rdataNext = wakeEn1Reg;
        end else if (wbReq.adr == ADDR_PD_RUN_CFG) begin
            rdataNext = pdRunCfgReg;
        end else if (wbReq.adr == ADDR_BUS_CLK_EN0) begin
            rdataNext = busClkEn0Reg;
        end else if (wbReq.adr == ADDR_BROWNOUT_CTRL) begin
            rdataNext = brownoutCtrlReg;
        end else if (wbReq.adr == ADDR_WDT_MODE) begin
            rdataNext = wdtModeReg;
        end else if (wbReq.adr == ADDR_RTC_OSC_CTRL) begin
            rdataNext = rtcOscCtrlReg;
        end else if (wbReq.adr == ADDR_PERIPH_KEEP) begin
            rdataNext = periphKeepReg;
        end else if (wbReq.adr == ADDR_STATUS) begin
            rdataNext = {29'h0, stateReg};
        end else if (wbReq.adr == ADDR_WAKE_CAUSE) begin
            rdataNext = wakeCauseReg;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ackReg <= 1'b0;
            rdataReg <= RST_ZERO;
        end else begin
            ackReg <= busHit;
            rdataReg <= busHit ? rdataNext : RST_ZERO;
        end
    end
    assign wbRsp = '{ack: ackReg, dat: rdataReg};

    // power and clock outputs, all registered from the next state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            coreClkEn <= 1'b1;
            mainClkEn <= 1'b1;
            periphClkEn <= '1;
            flashStandby <= 1'b0;
            analogPowerOn <= RST_PD_RUN_CFG[4:0];
            dmaEn <= 1'b1;
            retainState <= 1'b1;
            pinHold <= 1'b0;
            pinFloat <= 1'b0;
            coreResume <= 1'b0;
            chipResetReq <= 1'b0;
            powerState <= MODE_ACTIVE;
        end else begin
            coreResume <= stateReg != ST_ACTIVE && stateNext == ST_ACTIVE;
            chipResetReq <= stateNext == ST_POR_SEQ;
            case (stateNext)
                ST_SLEEP: begin
                    coreClkEn <= 1'b0;
                    mainClkEn <= 1'b1;
                    periphClkEn <= periphKeepClock;
                    flashStandby <= 1'b0;
                    analogPowerOn <= '1;
                    dmaEn <= 1'b1;
                    retainState <= 1'b1;
                    pinHold <= 1'b1;
                    pinFloat <= 1'b0;
                    powerState <= MODE_SLEEP;
                end
                ST_DEEP_SLEEP: begin
                    coreClkEn <= 1'b0;
                    mainClkEn <= 1'b0;
                    periphClkEn <= periphKeepClock & {PER_W{1'b0}};
                    flashStandby <= 1'b1;
                    analogPowerOn <= pdRunCfgReg[4:0] & ~(5'h1 << PD_FLASH_AWAKE);
                    dmaEn <= periphKeepReg[PK_DMA_DS];
                    retainState <= 1'b1;
                    pinHold <= 1'b1;
                    pinFloat <= 1'b0;
                    powerState <= MODE_DEEP_SLEEP;
                end
                ST_DEEP_PD: begin
                    coreClkEn <= 1'b0;
                    mainClkEn <= 1'b0;
                    periphClkEn <= '0;
                    flashStandby <= 1'b1;
                    analogPowerOn <= 5'(rtcOscCtrlReg[RTC_OSC_1HZ]) << PD_RTC_OSC;
                    dmaEn <= 1'b0;
                    retainState <= 1'b0;
                    pinHold <= 1'b0;
                    pinFloat <= 1'b1;
                    powerState <= MODE_DEEP_PD;
                end
                ST_POR_SEQ: begin
                    coreClkEn <= 1'b0;
                    mainClkEn <= 1'b1;
                    periphClkEn <= '0;
                    flashStandby <= 1'b0;
                    analogPowerOn <= RST_PD_RUN_CFG[4:0];
                    dmaEn <= 1'b0;
                    retainState <= 1'b0;
                    pinHold <= 1'b0;
                    pinFloat <= 1'b1;
                    powerState <= MODE_DEEP_PD;
                end
                default: begin
                    coreClkEn <= 1'b1;
                    mainClkEn <= 1'b1;
                    periphClkEn <= '1;
                    flashStandby <= 1'b0;
                    analogPowerOn <= '1;
                    dmaEn <= 1'b1;
                    retainState <= 1'b1;
                    pinHold <= 1'b0;
                    pinFloat <= 1'b0;
                    powerState <= MODE_ACTIVE;
                end
            endcase
        end
    end
endmodule

// ### lp_pkg.sv
/*
 * Package for the low-power mode and wake controller: register map, field
 * positions, reset values, mode and state enumerations, bus carrier structs.
 * Assumes a single 200 MHz system clock and a classic Wishbone master.
 */
package lp_pkg;
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WAKE_EN0 = 8'h04;
    localparam logic [7:0] ADDR_WAKE_EN1 = 8'h08;
    localparam logic [7:0] ADDR_PD_RUN_CFG = 8'h0C;
    localparam logic [7:0] ADDR_BUS_CLK_EN0 = 8'h10;
    localparam logic [7:0] ADDR_BROWNOUT_CTRL = 8'h14;
    localparam logic [7:0] ADDR_WDT_MODE = 8'h18;
    localparam logic [7:0] ADDR_RTC_OSC_CTRL = 8'h1C;
    localparam logic [7:0] ADDR_PERIPH_KEEP = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;
    localparam logic [7:0] ADDR_WAKE_CAUSE = 8'h28;

    // mode control: bits 1:0 requested mode, bit 2 enter strobe (self-clearing)
    localparam int MODE_LSB = 0;
    localparam int ENTER_BIT = 2;
    // wake start-enable 0 bit positions
    localparam int WE_BROWNOUT = 0;
    localparam int WE_WATCHDOG = 1;
    localparam int WE_RTC_ALARM = 2;
    localparam int WE_USART = 3;
    localparam int WE_SPI = 4;
    localparam int WE_I2C = 5;
    localparam int WE_DMA = 6;
    // power_down_run_config: bit set keeps the block running in deep-sleep, except PD_FLASH_AWAKE, which is masked off
    localparam int PD_FRO = 0;
    localparam int PD_WDT_OSC = 1;
    localparam int PD_BROWNOUT = 2;
    localparam int PD_RTC_OSC = 3;
    localparam int PD_FLASH_AWAKE = 4;
    localparam int BUS_CLK_RTC = 0;
    localparam int BO_INT_EN = 0;
    localparam int BO_RST_EN = 1;
    localparam int WDM_ENABLE = 0;
    localparam int WDM_RESET = 1;
    localparam int WDM_INT = 2;
    localparam int RTC_OSC_1HZ = 0;
    // peripheral keep-alive: slave-mode / 32 kHz-mode flags and dma-in-deep-sleep
    localparam int PK_USART_SYNC = 0;
    localparam int PK_USART_32K = 1;
    localparam int PK_SPI_SLAVE = 2;
    localparam int PK_I2C_SLAVE = 3;
    localparam int PK_DMA_DS = 4;

    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_PD_RUN_CFG = 32'h0000_0001;
    localparam int PIN_IRQ_W = 8;
    localparam int PERIPH_W = 16;
    localparam int POR_SEQ_CYCLES = 16;

    typedef enum logic [1:0] {MODE_ACTIVE, MODE_SLEEP, MODE_DEEP_SLEEP, MODE_DEEP_PD}
        lp_mode_e;
    typedef enum logic [2:0] {ST_ACTIVE, ST_SLEEP, ST_DEEP_SLEEP, ST_DEEP_PD, ST_POR_SEQ}
        lp_state_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_s;

    // wake sources from peripherals and core-side interrupt controller
    typedef struct packed {
        logic [PIN_IRQ_W-1:0] pinIrq;
        logic groupIrq;
        logic brownoutIrq;
        logic brownoutRst;
        logic watchdogIrq;
        logic watchdogRst;
        logic watchdogFed;
        logic oneHertzAlarmFlag;
        logic usartIrq;
        logic spiIrq;
        logic i2cIrq;
        logic dmaIrq;
        logic hardwareWakeRequest;
    } wake_src_s;
endpackage

// ### low_power_mode_wake_control_props.sv
/* checker: mode, wake and bus timing at the controller ports.
   assumes it is bound onto low_power_mode_wake_control, one clock domain */
`timescale 1ns/1ps
module low_power_mode_wake_control_props
    import lp_pkg::*;
#(parameter int PER_W = 16) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire lp_pkg::wb_req_s wbReq,
    input wire lp_pkg::wb_rsp_s wbRsp,
    input wire lp_pkg::wake_src_s wakeSrc,
    input wire logic [31:0] irqEnabledPending,
    input wire logic [PER_W-1:0] periphKeepClock,
    input wire logic coreClkEn,
    input wire logic mainClkEn,
    input wire logic [PER_W-1:0] periphClkEn,
    input wire logic dmaEn,
    input wire logic retainState,
    input wire logic pinHold,
    input wire logic pinFloat,
    input wire logic coreResume,
    input wire logic chipResetReq,
    input wire logic rtcWakeIrq,
    input wire logic [1:0] powerState
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_wbAck;
        wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack ##1 !wbRsp.ack;
    endproperty
    property p_sleep; powerState == 2'h1 |-> !coreClkEn && dmaEn && retainState && pinHold
        && periphClkEn == periphKeepClock; endproperty
    property p_wake; powerState == 2'h1 && (|irqEnabledPending || wakeSrc.hardwareWakeRequest)
        |=> powerState == 2'h0 && coreResume; endproperty
    property p_deep; powerState == 2'h2 |-> !coreClkEn && !mainClkEn && periphClkEn == '0
        && pinHold && retainState; endproperty
    // entry from active only, so reset-sequence tails never match
    property p_pd; $past(powerState) == 2'h0 && powerState == 2'h3
        |-> pinFloat && !dmaEn && !retainState; endproperty
    // the reset sequence also floats pins; only true power-down must hold still
    property p_pdStay; pinFloat && !chipResetReq && !rtcWakeIrq
        |=> powerState == 2'h3 && !chipResetReq; endproperty
    property p_alarm; $rose(wakeSrc.oneHertzAlarmFlag) |=> rtcWakeIrq; endproperty
    property p_pdWake; pinFloat && rtcWakeIrq |-> ##[0:3] chipResetReq; endproperty
    property p_seq; $rose(chipResetReq) |-> ##15 chipResetReq ##[1:3] !chipResetReq; endproperty
    a_wbAck: assert property (p_wbAck) else $error("bus ack timing");
    a_sleep: assert property (p_sleep) else $error("sleep outputs");
    a_wake: assert property (p_wake) else $error("sleep exit");
    a_deep: assert property (p_deep) else $error("deep-sleep outputs");
    a_pd: assert property (p_pd) else $error("power-down outputs");
    a_pdStay: assert property (p_pdStay) else $error("power-down left");
    a_alarm: assert property (p_alarm) else $error("alarm request");
    a_pdWake: assert property (p_pdWake) else $error("alarm wake");
    a_seq: assert property (p_seq) else $error("reset length");
    c_wake: cover property (powerState == 2'h1 ##1 coreResume);
    c_alarm: cover property (pinFloat && rtcWakeIrq);
    c_seq: cover property ($fell(chipResetReq));
endmodule
bind low_power_mode_wake_control low_power_mode_wake_control_props #(.PER_W(PER_W)) props (.*);

// ### wake_source_model.sv
/* wake source model: peripherals and interrupt controller in front of the block.
   assumes the bench sets raised events and controller enables */
`timescale 1ns/1ps
module wake_source_model
    import lp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire lp_pkg::wake_src_s evt,
    input wire logic [31:0] ctlEn,
    output lp_pkg::wake_src_s wakeSrc,
    output logic [31:0] irqEnabledPending,
    output logic [31:0] irqSrcMap,
    output logic rtcCounterLoaded,
    output logic [lp_pkg::PERIPH_W-1:0] periphKeepClock
);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeSrc <= '0;
            irqEnabledPending <= 32'h0;
            irqSrcMap <= 32'h0;
            rtcCounterLoaded <= 1'b0;
            periphKeepClock <= 16'h0;
        end else begin
            wakeSrc <= evt;
            irqSrcMap <= ctlEn;
            // a source pends only once the controller has it enabled
            irqEnabledPending <= {22'h0, ctlEn[9:0] & {evt.watchdogIrq, evt.brownoutIrq,
                evt.pinIrq}};
            rtcCounterLoaded <= 1'b1;
            periphKeepClock <= 16'h00F0;
        end
    end
endmodule

// ### low_power_mode_wake_control_test.sv
/* bench: register access over classic wishbone, mode entry and wake scenarios.
   assumes the wake source model feeds every wake input of the block */
`timescale 1ns/1ps
module low_power_mode_wake_control_test;
    import lp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    wb_req_s wbReq = '0;
    wb_rsp_s wbRsp;
    wake_src_s evt = '0;
    wake_src_s wakeSrc;
    logic [31:0] ctlEn = 32'h0, irqEnabledPending, irqSrcMap, rd;
    logic rtcCounterLoaded, coreClkEn, mainClkEn, flashStandby, dmaEn, retainState, pinHold;
    logic pinFloat, coreResume, chipResetReq, rtcWakeIrq;
    logic [15:0] periphKeepClock, periphClkEn;
    logic [4:0] analogPowerOn;
    logic [1:0] powerState;
    int failCount = 0;
    int nChecks = 0;
    int resetCycles = 0;
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (chipResetReq === 1'b1) resetCycles++;
    wake_source_model model (.*);
    low_power_mode_wake_control dut (.*);
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        wbReq <= '{1'b1, 1'b1, w, a, 4'hF, d};
        @(posedge sys_clk);
        while (wbRsp.ack !== 1'b1) @(posedge sys_clk);
        rd = wbRsp.dat;
        wbReq <= '0;
        @(posedge sys_clk);
    endtask
    task automatic waitState(input logic [1:0] s);
        repeat (64) if (powerState !== s) @(posedge sys_clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        wb(0, ADDR_PD_RUN_CFG, 0);
        chk("pdcfg", rd, RST_PD_RUN_CFG);
        wb(0, 8'h3C, 0);
        chk("unmapped", rd, 32'h0);
        wb(1, ADDR_MODE_CTRL, 32'h5);
        @(posedge sys_clk);
        chk("coreclk", 32'(coreClkEn), 32'h0);
        chk("keep", 32'(periphClkEn), 32'h00F0);
        chk("dma", 32'(dmaEn), 32'h1);
        evt <= '{hardwareWakeRequest: 1'b1, default: '0};
        waitState(2'h0);
        chk("hardware_wake_request", 32'(powerState), 32'h0);
        evt <= '0;
        wb(1, ADDR_WAKE_EN1, 32'h1);
        wb(1, ADDR_MODE_CTRL, 32'h6);
        @(posedge sys_clk);
        chk("mainclk", 32'(mainClkEn), 32'h0);
        chk("flash", 32'(flashStandby), 32'h1);
        chk("analog", 32'(analogPowerOn), 32'h1);
        evt <= '{pinIrq: 8'h01, default: '0};
        repeat (10) @(posedge sys_clk);
        chk("pin gated", 32'(powerState), 32'h2);
        ctlEn <= 32'h1;
        waitState(2'h0);
        chk("pin wake", 32'(powerState), 32'h0);
        evt <= '0;
        ctlEn <= 32'h0;
        wb(0, ADDR_WAKE_CAUSE, 0);
        chk("cause pin", rd, 32'h1);
        wb(1, ADDR_WAKE_CAUSE, 32'h1);
        wb(1, ADDR_BROWNOUT_CTRL, 32'h2);
        wb(1, ADDR_MODE_CTRL, 32'h6);
        evt <= '{brownoutRst: 1'b1, default: '0};
        repeat (3) @(posedge sys_clk);
        evt <= '0;
        waitState(2'h0);
        chk("bo seq", resetCycles, POR_SEQ_CYCLES);
        wb(0, ADDR_BROWNOUT_CTRL, 0);
        chk("bo wiped", rd, 32'h0);
        wb(0, ADDR_WAKE_CAUSE, 0);
        chk("cause bo", rd, 32'h20);
        wb(1, ADDR_PERIPH_KEEP, 32'h1);
        wb(1, ADDR_WAKE_EN0, 32'h8);
        wb(1, ADDR_MODE_CTRL, 32'h6);
        evt <= '{usartIrq: 1'b1, default: '0};
        waitState(2'h0);
        evt <= '0;
        chk("usart wake", 32'(powerState), 32'h0);
        wb(1, ADDR_WDT_MODE, 32'h7);
        wb(1, ADDR_WDT_MODE, 32'h0);
        wb(0, ADDR_WDT_MODE, 0);
        chk("wdt lock", rd, 32'h7);
        wb(1, ADDR_RTC_OSC_CTRL, 32'h1);
        wb(1, ADDR_BUS_CLK_EN0, 32'h1);
        wb(1, ADDR_WAKE_EN0, 32'h4);
        wb(1, ADDR_MODE_CTRL, 32'h7);
        @(posedge sys_clk);
        chk("float", 32'(pinFloat), 32'h1);
        chk("pd dma", 32'(dmaEn), 32'h0);
        chk("retain", 32'(retainState), 32'h0);
        evt <= '{pinIrq: 8'h01, default: '0};
        ctlEn <= 32'h1;
        repeat (10) @(posedge sys_clk);
        chk("pd stays", 32'(powerState), 32'h3);
        evt <= '{oneHertzAlarmFlag: 1'b1, default: '0};
        ctlEn <= 32'h0;
        repeat (4) @(posedge sys_clk);
        chk("alarm irq", 32'(rtcWakeIrq), 32'h1);
        waitState(2'h0);
        chk("pd wake", 32'(powerState), 32'h0);
        chk("pd seq", resetCycles, 2 * POR_SEQ_CYCLES);
        end_sim();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        failCount++;
        end_sim();
    end
endmodule
